// >>> logic/pms_io_lines.sv
// Purpose: three 8-line I/O groups with mode decode, LCD and serial alternate uses
// Assumes: pin levels may be asynchronous, hence the two-stage synchroniser; AXI4-Lite slave, one access of each kind at a time
// Notes: outputs are registered, so a register write reaches the pins one cycle after bresp
//        interrupt trigger choice, the converter and the segment driver sit outside
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.

`timescale 1ns/1ps

module pms_io_lines (
    // ------------------------------------------------------------
    // clock and reset
    // ------------------------------------------------------------
    input wire logic clock,
    input wire logic rst,
    // ------------------------------------------------------------
    // register bus, write channels
    // ------------------------------------------------------------
    input wire logic [pms_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // ------------------------------------------------------------
    // register bus, read channels
    // ------------------------------------------------------------
    input wire logic [pms_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // ------------------------------------------------------------
    // pin side and alternate users
    // ------------------------------------------------------------
    input wire logic [2:0][7:0] pin_in,
    output pms_pkg::pms_pads_s pads,
    input wire logic [7:0] lcd_segments_33_to_40,
    output logic [pms_pkg::ADC_CH-1:0] adc_sel,
    output logic [2:0][7:0] line_level,
    // ------------------------------------------------------------
    // serial unit
    // ------------------------------------------------------------
    input wire logic spi_sout,
    output logic spi_sin,
    output logic spi_scl
);

    typedef struct packed {
        // register image
        pms_pkg::pms_grp_s [2:0] grp;
        // two-stage pin synchroniser
        logic [2:0][7:0] sync1;
        logic [2:0][7:0] sync2;
        // write path
        logic aw_got;
        logic w_got;
        logic [pms_pkg::IDX_W-1:0] w_idx;
        logic [7:0] w_byte;
        logic w_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        // read path
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        // pad-side outputs
        pms_pkg::pms_pads_s pads;
        logic [pms_pkg::ADC_CH-1:0] adc_sel;
        logic spi_sin;
        logic spi_scl;
    } pms_state_s;

    // all state in one image; rst_st is its constant reset copy
    pms_state_s st;
    pms_state_s next_st;
    pms_state_s rst_st;

    // ----------------------------------------------------------------
    // per-line mode decode
    // ----------------------------------------------------------------
    // combinational pad image, registered into st.pads one edge later
    pms_pkg::pms_pads_s line_pads;
    logic [pms_pkg::ADC_CH-1:0] line_adc;
    logic [2:0][7:0] read_value;

    // one copy of the decode per line; group and line fix which options exist
    genvar g, n;
    generate
        for (g = 0; g < 3; g++) begin : gen_grp
            for (n = 0; n < 8; n++) begin : gen_line
                localparam bit HAS_ADC = (g == pms_pkg::GRP_A) ||
                    (g == pms_pkg::GRP_B && n < pms_pkg::ANALOG_B_LINES);
                localparam bit HAS_LCD = (g == pms_pkg::GRP_C);
                localparam bit IS_SOUT = (g == pms_pkg::GRP_B && n == pms_pkg::SPI_SOUT_LINE);
                logic d;
                logic o;
                logic v;
                logic special;
                logic od_level;
                assign d = st.grp[g].dir[n];
                assign o = st.grp[g].cfg[n];
                assign v = st.grp[g].value[n];
                assign special = !d && o && v;
                // serial transmit only merges in open-drain mode
                assign od_level = IS_SOUT ? (v & spi_sout) : v;
                // pull and interrupt follow the stored latch, never the pin
                assign line_pads.pull_en[g][n] = !d && !v;
                assign line_pads.irq_en[g][n] = !d && o && !v;
                assign line_pads.lcd_en[g][n] = HAS_LCD && special;
                // push-pull, then open-drain, then segment drive, else released
                assign line_pads.out[g][n] = (d && o) ? v :
                    (d ? 1'b0 :
                    ((HAS_LCD && special) ? lcd_segments_33_to_40[n] : 1'b0));
                assign line_pads.oe[g][n] = (d && o) ? 1'b1 :
                    (d ? !od_level :
                    (HAS_LCD && special));
                if (HAS_ADC) begin : gen_adc
                    assign line_adc[g * 8 + n] = special;
                end
                // input lines read the pin, output lines the latch
                assign read_value[g][n] = d ? v : st.sync2[g][n];
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // reset image
    // ----------------------------------------------------------------
    always_comb begin
        rst_st = '0;
        for (int k = 0; k < 3; k++) begin
            rst_st.grp[k].dir = pms_pkg::RST_DIR;
            rst_st.grp[k].cfg = pms_pkg::RST_CFG_AB;
            rst_st.grp[k].value = pms_pkg::RST_VALUE_AB;
        end
        // group C wakes up driving segments, so its option and latch start all ones
        // while its direction, like every other register, starts cleared
        rst_st.grp[pms_pkg::GRP_C].cfg = pms_pkg::RST_CFG_C;
        rst_st.grp[pms_pkg::GRP_C].value = pms_pkg::RST_VALUE_C;
        rst_st.pads.pull_en[pms_pkg::GRP_A] = 8'hFF;
        rst_st.pads.pull_en[pms_pkg::GRP_B] = 8'hFF;
        rst_st.pads.lcd_en[pms_pkg::GRP_C] = 8'hFF;
        rst_st.pads.oe[pms_pkg::GRP_C] = 8'hFF;
    end

    // ----------------------------------------------------------------
    // register decode helpers
    // ----------------------------------------------------------------
    // an index outside the map answers with an error rather than aliasing a register,
    // so a stray address never disturbs a pin
    function automatic logic idx_hit(input logic [pms_pkg::IDX_W-1:0] idx);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < 3; k++) begin
            if (idx == pms_pkg::IDX_VALUE[k] || idx == pms_pkg::IDX_DIR[k] ||
                idx == pms_pkg::IDX_CFG[k]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [pms_pkg::IDX_W-1:0] r_idx;
        logic [7:0] r_byte;
        next_st = st;
        r_idx = s_axi_araddr[pms_pkg::IDX_LSB +: pms_pkg::IDX_W];
        r_byte = 8'h00;

        // ------------------------------------------------------------
        // pin synchroniser
        // ------------------------------------------------------------
        // first stage feeds only the second
        next_st.sync1 = pin_in;
        next_st.sync2 = st.sync1;

        // ------------------------------------------------------------
        // write address and data capture
        // ------------------------------------------------------------
        // write address and data may arrive in either order
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_got = 1'b1;
            next_st.awready = 1'b0;
            next_st.w_idx = s_axi_awaddr[pms_pkg::IDX_LSB +: pms_pkg::IDX_W];
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_got = 1'b1;
            next_st.wready = 1'b0;
            next_st.w_byte = s_axi_wdata[7:0];
            next_st.w_lane0 = s_axi_wstrb[0];
        end

        // ------------------------------------------------------------
        // write commit
        // ------------------------------------------------------------
        // a write without lane 0 is acknowledged but changes nothing
        if (st.aw_got && st.w_got && !st.bvalid) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = idx_hit(st.w_idx) ? pms_pkg::RESP_OKAY : pms_pkg::RESP_SLVERR;
            for (int k = 0; k < 3; k++) begin
                if (st.w_lane0) begin
                    // whole byte lands at once; no per-bit merge
                    if (st.w_idx == pms_pkg::IDX_DIR[k]) begin
                        next_st.grp[k].dir = st.w_byte;
                    end
                    if (st.w_idx == pms_pkg::IDX_CFG[k]) begin
                        next_st.grp[k].cfg = st.w_byte;
                    end
                    if (st.w_idx == pms_pkg::IDX_VALUE[k]) begin
                        next_st.grp[k].value = st.w_byte;
                    end
                end
            end
        end

        // ------------------------------------------------------------
        // write response
        // ------------------------------------------------------------
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready = 1'b1;
        end
        // ready returns only once the response is gone, so one write at a time
        if (!st.aw_got && !st.w_got && !st.bvalid) begin
            next_st.awready = !(s_axi_awvalid && st.awready);
            next_st.wready = !(s_axi_wvalid && st.wready);
        end

        // ------------------------------------------------------------
        // read decode
        // ------------------------------------------------------------
        for (int k = 0; k < 3; k++) begin
            if (r_idx == pms_pkg::IDX_VALUE[k]) begin
                r_byte = read_value[k];
            end
            if (r_idx == pms_pkg::IDX_DIR[k]) begin
                r_byte = st.grp[k].dir;
            end
            if (r_idx == pms_pkg::IDX_CFG[k]) begin
                r_byte = st.grp[k].cfg;
            end
        end

        // ------------------------------------------------------------
        // read answer
        // ------------------------------------------------------------
        if (s_axi_arvalid && st.arready) begin
            next_st.arready = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rdata = {24'h000000, r_byte};
            next_st.rresp = idx_hit(r_idx) ? pms_pkg::RESP_OKAY : pms_pkg::RESP_SLVERR;
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
            next_st.arready = 1'b1;
        end else if (!st.rvalid) begin
            next_st.arready = 1'b1;
        end

        // ------------------------------------------------------------
        // pad side
        // ------------------------------------------------------------
        // registered so every output leaves a flip-flop
        next_st.pads = line_pads;
        next_st.adc_sel = line_adc;
        // serial inputs stay ordinary readable inputs in every input mode
        next_st.spi_sin = st.sync2[pms_pkg::GRP_B][pms_pkg::SPI_SIN_LINE];
        next_st.spi_scl = st.sync2[pms_pkg::GRP_B][pms_pkg::SPI_SCL_LINE];

        // ------------------------------------------------------------
        // reset override
        // ------------------------------------------------------------
        if (rst) begin
            next_st = rst_st;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        st <= next_st;
    end

    // ----------------------------------------------------------------
    // bus outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;

    // ----------------------------------------------------------------
    // pin side outputs
    // ----------------------------------------------------------------
    assign pads = st.pads;
    assign adc_sel = st.adc_sel;
    // interrupt trigger logic (edge or level choice) sits outside and uses these
    assign line_level = st.sync2;
    assign spi_sin = st.spi_sin;
    assign spi_scl = st.spi_scl;

endmodule // pms_io_lines

// >>> logic/pms_pkg.sv
// Purpose: constants and carrier types for the pin mode select block
// Assumes: AXI4-Lite register access, 32-bit data, 8-bit registers in the low byte
// Notes: printed offsets are register indices; byte address is four times the index

package pms_pkg;

    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int AXI_AW = 12;
    localparam int IDX_LSB = 2;
    localparam int IDX_W = 10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // register indices, entry g is group A, B, C for g = 0, 1, 2
    // ----------------------------------------------------------------
    localparam logic [2:0][9:0] IDX_VALUE = {10'h0C3, 10'h0C1, 10'h0C0};
    localparam logic [2:0][9:0] IDX_DIR = {10'h0C6, 10'h0C5, 10'h0C4};
    localparam logic [2:0][9:0] IDX_CFG = {10'h0CF, 10'h0CE, 10'h0CC};

    // ----------------------------------------------------------------
    // values after reset
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_DIR = 8'h00;
    localparam logic [7:0] RST_CFG_AB = 8'h00;
    localparam logic [7:0] RST_VALUE_AB = 8'h00;
    localparam logic [7:0] RST_CFG_C = 8'hFF;
    localparam logic [7:0] RST_VALUE_C = 8'hFF;

    // ----------------------------------------------------------------
    // line positions of special functions
    // ----------------------------------------------------------------
    localparam int GRP_A = 0;
    localparam int GRP_B = 1;
    localparam int GRP_C = 2;
    localparam int ANALOG_B_LINES = 4;
    localparam int ADC_CH = 12;
    localparam int SPI_SCL_LINE = 5;
    localparam int SPI_SIN_LINE = 6;
    localparam int SPI_SOUT_LINE = 7;

    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] cfg;
        logic [7:0] value;
    } pms_grp_s;

    typedef struct packed {
        logic [2:0][7:0] out;
        logic [2:0][7:0] oe;
        logic [2:0][7:0] pull_en;
        logic [2:0][7:0] irq_en;
        logic [2:0][7:0] lcd_en;
    } pms_pads_s;

endpackage : pms_pkg

// >>> testbench/pms_io_lines_asserts.sv
// Purpose: port-level checks for the pin mode select block
// Assumes: one clock, synchronous active-high reset
// Notes: up counts edges since reset so pipeline checks skip the refill
`timescale 1ns/1ps
module pms_io_lines_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [2:0][7:0] pin_in,
    input pms_pkg::pms_pads_s pads,
    input wire logic [7:0] lcd_segments_33_to_40,
    input wire logic [pms_pkg::ADC_CH-1:0] adc_sel,
    input wire logic [2:0][7:0] line_level,
    input wire logic spi_sin
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic [2:0] up;
    always_ff @(posedge clock) begin
        if (rst) up <= 3'h0;
        else if (up != 3'h7) up <= up + 3'h1;
    end
    sequence s_ar_taken; s_axi_arvalid && s_axi_arready; endsequence
    property p_rd_ans; s_ar_taken |=> s_axi_rvalid && !s_axi_arready; endproperty
    property p_irq_pull; (pads.irq_en & ~pads.pull_en) == 24'h0; endproperty
    property p_adc;
        adc_sel[7:0] != 8'h00 |->
            (adc_sel[7:0] & (pads.oe[0] | pads.pull_en[0] | pads.irq_en[0])) == 8'h00;
    endproperty
    property p_lcd_oe; (pads.lcd_en[2] & ~pads.oe[2]) == 8'h00; endproperty
    property p_lcd_out;
        up > 3'h1 |-> ((pads.out[2] ^ $past(lcd_segments_33_to_40)) & pads.lcd_en[2]) == 8'h00;
    endproperty
    property p_rst_state;
        up == 3'h1 |-> pads.pull_en[1:0] == 16'hFFFF && pads.lcd_en[2] == 8'hFF;
    endproperty
    property p_level; up > 3'h3 |-> line_level == $past(pin_in, 2); endproperty
    property p_sin; up > 3'h4 |-> spi_sin == $past(pin_in[1][6], 3); endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
    a_irq_pull: assert property (p_irq_pull) else $error("irq without pull-up");
    a_adc: assert property (p_adc) else $error("analog line also driven");
    a_lcd_oe: assert property (p_lcd_oe) else $error("segment not driven");
    a_lcd_out: assert property (p_lcd_out) else $error("segment data wrong");
    a_rst_state: assert property (p_rst_state) else $error("bad state after reset");
    a_level: assert property (p_level) else $error("line level not synced");
    a_sin: assert property (p_sin) else $error("serial in not synced");
endmodule // pms_io_lines_chk

bind pms_io_lines pms_io_lines_chk u_chk (.clock, .rst, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .pin_in, .pads, .lcd_segments_33_to_40, .adc_sel, .line_level, .spi_sin);

// >>> testbench/pms_pins_model.sv
// Purpose: pin-side model for the pin mode select block
// Assumes: a line with an enabled output wins over any outside driver
// Notes: undriven lines without pull-up toggle every cycle so they never look stable
`timescale 1ns/1ps
module pms_pins_model (
    input wire logic clock,
    input pms_pkg::pms_pads_s pads,
    input wire logic [2:0][7:0] ext_en,
    input wire logic [2:0][7:0] ext_val,
    output logic [2:0][7:0] pin_in = '0
);
    always @(posedge clock) begin
        for (int g = 0; g < 3; g++) begin
            for (int n = 0; n < 8; n++) begin
                if (pads.oe[g][n]) begin
                    pin_in[g][n] <= pads.out[g][n];
                end else if (ext_en[g][n]) begin
                    pin_in[g][n] <= ext_val[g][n];
                end else if (pads.pull_en[g][n]) begin
                    pin_in[g][n] <= 1'b1;
                end else begin
                    pin_in[g][n] <= ~pin_in[g][n];
                end
            end
        end
    end
endmodule // pms_pins_model

// >>> testbench/testbench.sv
// Purpose: self-checking bench for the pin mode select block
// Assumes: bus master drives by non-blocking assignment right after rising edges
// Notes: expected pad values are worked out per line from the mode table
`timescale 1ns/1ps
module testbench;
    localparam logic [2:0][9:0] VA = pms_pkg::IDX_VALUE;
    localparam logic [2:0][9:0] DI = pms_pkg::IDX_DIR;
    localparam logic [2:0][9:0] CF = pms_pkg::IDX_CFG;
    localparam logic [1:0] OK = pms_pkg::RESP_OKAY;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h0;
    logic [11:0] s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, spi_sout = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic spi_sin, spi_scl;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [2:0][7:0] pin_in, line_level;
    logic [2:0][7:0] ext_en = '0, ext_val = '0;
    logic [7:0] lcd_segments_33_to_40 = 8'hA5;
    logic [11:0] adc_sel;
    pms_pkg::pms_pads_s pads;
    int n_fail = 0, num_checks = 0, cyc = 0;

    pms_io_lines u_dut (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pads, .lcd_segments_33_to_40,
        .adc_sel, .line_level, .spi_sout, .spi_sin, .spi_scl);
    pms_pins_model u_pins (.clock, .pads, .ext_en, .ext_val, .pin_in);

    always #2.5 clock = ~clock;

    task automatic close_out();
        if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // the whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // ----------------------------------------------------------------
    // bus cycles
    // ----------------------------------------------------------------
    task automatic wr(input logic [9:0] i, input logic [7:0] d, input logic [1:0] er);
        @(posedge clock);
        s_axi_awaddr <= {i, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask
    task automatic rd(input logic [9:0] i, input logic [7:0] ed, input logic [1:0] er);
        @(posedge clock);
        s_axi_araddr <= {i, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, {24'h0, ed});
        chk(32'(s_axi_rresp), 32'(er));
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        for (int g = 0; g < 3; g++) begin
            rd(DI[g], 8'h00, OK);
            rd(CF[g], (g == 2) ? 8'hFF : 8'h00, OK);
        end
        chk(32'(pads.pull_en[1:0]), 32'hFFFF);
        chk(32'(pads.irq_en), 32'h0);
        chk(32'(pads.lcd_en[2]), 32'hFF);
        lcd_segments_33_to_40 <= 8'h3C;
        repeat (2) @(posedge clock);
        chk(32'(pads.out[2]), 32'h3C);
    endtask
    // one line per mode on group A, input lines 0-3 driven from outside
    task automatic t_modes();
        ext_en[0] <= 8'h0F;
        ext_val[0] <= 8'h05;
        // direction first, option last: only line 3 ever becomes analog
        wr(DI[0], 8'hF0, OK);
        wr(VA[0], 8'h6A, OK);
        wr(CF[0], 8'hCC, OK);
        repeat (5) @(posedge clock);
        chk(32'(pads.pull_en[0]), 32'h05);
        chk(32'(pads.irq_en[0]), 32'h04);
        chk(32'(adc_sel), 32'h008);
        chk(32'(pads.oe[0]), 32'hD0);
        chk(32'(pads.out[0]), 32'h40);
        rd(VA[0], 8'h65, OK);
        ext_val[0] <= 8'h0A;
        repeat (5) @(posedge clock);
        chk(32'({pads.pull_en[0], pads.irq_en[0]}), 32'h0504);
        rd(VA[0], 8'h6A, OK);
        rd(DI[0], 8'hF0, OK);
        rd(CF[0], 8'hCC, OK);
        wr(CF[0], 8'h00, OK);
        wr(DI[0], 8'h00, OK);
    endtask
    task automatic t_analog();
        for (int n = 0; n < 8; n++) begin
            wr(CF[1], 8'(1 << n), OK);
            wr(VA[1], 8'(1 << n), OK);
            repeat (3) @(posedge clock);
            chk(32'(adc_sel), (n < 4) ? 32'h100 << n : 32'h0);
            chk(32'({pads.oe[1][n], pads.pull_en[1][n], pads.irq_en[1][n]}), 32'h0);
        end
    endtask
    task automatic t_spi();
        wr(DI[1], 8'h80, OK);
        wr(CF[1], 8'h00, OK);
        spi_sout <= 1'b0;
        repeat (3) @(posedge clock);
        chk(32'(pads.oe[1][7]), 32'h1);
        spi_sout <= 1'b1;
        repeat (3) @(posedge clock);
        chk(32'({pads.oe[1][7], pads.out[1][7]}), 32'h0);
        wr(CF[1], 8'h80, OK);
        spi_sout <= 1'b0;
        repeat (3) @(posedge clock);
        chk(32'({pads.oe[1][7], pads.out[1][7]}), 32'h3);
        ext_en[1] <= 8'h60;
        ext_val[1] <= 8'h20;
        repeat (6) @(posedge clock);
        chk(32'({spi_sin, spi_scl}), 32'h1);
        rd(VA[1], 8'hBF, OK);
        rd(10'h0C2, 8'h00, pms_pkg::RESP_SLVERR);
        wr(10'h0C2, 8'hFF, pms_pkg::RESP_SLVERR);
        rd(DI[1], 8'h80, OK);
    endtask

    initial begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_modes();
        t_analog();
        t_spi();
        close_out();
    end
endmodule // testbench
